/* File: logic/pssc_consts.svh */
// Constants of the synchronous SRAM cycle-control block: widths, timing and clock rate.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PSSC_CONSTS_SVH
`define PSSC_CONSTS_SVH

// Array organisation: 32K words of 32 bits in four byte lanes.
`define PSSC_ADDR_W 15
`define PSSC_DATA_W 32
`define PSSC_LANES 4
`define PSSC_BURST_W 2

// Clock period of mclk in nanoseconds (50 MHz).
`define PSSC_CLK_PERIOD_NS 20

// Sleep entry and recovery times, printed as two clock periods.
`define PSSC_SLEEP_ENTRY_TIME_NS (2 * `PSSC_CLK_PERIOD_NS)
`define PSSC_SLEEP_RECOVERY_TIME_NS (2 * `PSSC_CLK_PERIOD_NS)

// Entry is a longest time, so it rounds down to whole cycles.
`define PSSC_SLEEP_ENTRY_CYCLES (`PSSC_SLEEP_ENTRY_TIME_NS / `PSSC_CLK_PERIOD_NS)

// Burst order strap level that selects the linear sequence.
`define PSSC_ORDER_LINEAR 1'h0

`endif

/* File: logic/pssc_pkg.sv */
// Types shared by the SRAM cycle-control logic.
// Assumes the constants header is on the include path.
`include "pssc_consts.svh"

package pssc_pkg;

  // Kind of the cycle in progress, one-hot.
  typedef enum logic [3:0] {
    PSSC_ST_IDLE  = 4'h1,
    PSSC_ST_READ  = 4'h2,
    PSSC_ST_WRITE = 4'h4,
    PSSC_ST_SLEEP = 4'h8
  } pssc_cycle_t;

  typedef logic [`PSSC_BURST_W-1:0] pssc_burst_t;

endpackage

/* File: logic/pssc_top.sv */
// Cycle control and storage of a 32K x 32 pipelined synchronous SRAM.
// Assumes the bus controller drives every synchronous input from logic clocked by mclk;
// only the sleep request and the burst order strap come from outside that domain.
//
// Summary of operation
// - Strap low: burst low bits count up and wrap from the start value.
// - Strap high: burst low bits are the start value XOR 0,1,2,3.
// - Address bits one and zero load a two-bit wraparound burst counter.
// - Read data appears from the output register after the next clock edge.
// - Unselected byte lanes keep their contents during a byte write.
// - Sleep request is asynchronous and puts the memory into sleep.
// - Entering and leaving sleep each take two clock cycles.
// - Stored contents stay unchanged while asleep.
// - An access caught by sleep entry is invalid and may not complete.
// - Inactive enables with an active controller strobe, or with a processor strobe and primary enable low, give a deselect cycle.
// - Enabled processor strobe, or controller strobe without write, starts a read.
// - Processor strobe with all enables active starts a read whatever the write inputs say.
// - Writes occur only after a processor strobe or with a controller strobe.
// - Strobes high, advance low: the next burst address is read, or written if the write qualifier is active.
// - Strobes high, advance high: the current address is read again, or written if the write qualifier is active.
// - Write qualifier: global write low, or byte enable low with a lane low.
// - Data pins follow the cycle type and the unclocked output enable.
// - Output enable is masked during writes so the bus floats.
// - In reads after their first cycle, output enable low drives all bits; otherwise all float.
// - Enabled, controller strobe low, processor strobe high, write qualifier active: write at the external address.
`timescale 1ns/1ps
`include "pssc_consts.svh"

module pssc_top #(
  parameter int ADDR_W = `PSSC_ADDR_W,
  parameter int DATA_W = `PSSC_DATA_W,
  parameter int LANES  = `PSSC_LANES
) (
  input  wire logic                 mclk,                          // System clock, 50 MHz.
  input  wire logic                 rst,                           // Synchronous reset, active high.
  input  wire logic                 sleep_request,                 // Asynchronous sleep request.
  input  wire logic                 burst_order_strap,             // Low selects linear, high interleaved.
  input  wire logic                 chip_enable_primary_n,         // Primary chip enable, low active.
  input  wire logic                 chip_enable_secondary,         // Secondary chip enable, high active.
  input  wire logic                 chip_enable_tertiary_n,        // Tertiary chip enable, low active.
  input  wire logic                 processor_address_strobe_n,    // Processor address strobe.
  input  wire logic                 controller_address_strobe_n,   // Controller address strobe.
  input  wire logic                 burst_advance_n,               // Burst advance, low active.
  input  wire logic                 global_write_n,                // Write all lanes, low active.
  input  wire logic                 byte_write_enable_n,           // Byte write enable, low active.
  input  wire logic [LANES-1:0]     byte_lane_select_n,            // Per-lane write selects.
  input  wire logic                 output_enable_n,               // Unclocked output enable.
  input  wire logic [ADDR_W-1:0]    address,                       // Word address.
  input  wire logic [DATA_W-1:0]    data_in,                       // Data pin input level.
  output      logic [DATA_W-1:0]    data_out,                      // Data pin output value.
  output      logic [DATA_W-1:0]    data_oe,                       // Data pin output enables.
  output      logic                 sleep_active,                  // High while asleep.
  output      pssc_pkg::pssc_cycle_t cycle_state                   // Cycle in progress.
);
  import pssc_pkg::*;

  localparam int LANE_W   = DATA_W / LANES;
  localparam int DEPTH    = 1 << ADDR_W;
  localparam int SYNC_LEN = `PSSC_SLEEP_ENTRY_CYCLES;

  // Write qualifier shared by decode and lane enables.
  function automatic logic write_qual(input logic gw_n, input logic bwe_n, input logic [LANES-1:0] bw_n);
    write_qual = !gw_n || (!bwe_n && !(&bw_n));
  endfunction

  // Low address bits of burst beat k from a start value in either order.
  function automatic pssc_burst_t burst_low(input pssc_burst_t start, input pssc_burst_t k, input logic lin);
    if (lin) begin
      burst_low = pssc_burst_t'(start + k);
    end else begin
      burst_low = start ^ k;
    end
  endfunction

  logic [SYNC_LEN-1:0]      sleep_sync_q;
  logic [1:0]               order_sync_q;
  logic                     asleep;
  logic                     linear;
  pssc_cycle_t              state_q;
  pssc_cycle_t              state_d;
  logic [ADDR_W-1:2]        base_q;
  pssc_burst_t              start_q;
  pssc_burst_t              step_q;
  logic                     load_ext;
  logic                     step_en;
  logic                     wr_en;
  logic                     rd_use;
  logic                     ce_all;
  logic                     wq;
  logic [ADDR_W-1:0]        cur_addr;
  logic [ADDR_W-1:0]        next_addr;
  logic [ADDR_W-1:0]        acc_addr;
  logic                     rd_pend_q;
  logic [ADDR_W-1:0]        rd_addr_q;
  logic                     drive_q;
  logic [DATA_W-1:0]        data_out_q;
  logic [LANES-1:0]         lane_we;
  logic [DATA_W-1:0]        mem [0:DEPTH-1];

  // Sleep request synchroniser; its depth equals the two-cycle entry and exit time,
  // so the sleep state changes on the second edge after the request moves.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_sync_q <= '0;
    end else begin
      sleep_sync_q <= {sleep_sync_q[SYNC_LEN-2:0], sleep_request};
    end
  end
  assign asleep = sleep_sync_q[SYNC_LEN-1];

  // The strap is a static pin level but is still synchronised, since it may float.
  always_ff @(posedge mclk) begin
    if (rst) begin
      order_sync_q <= 2'h3;
    end else begin
      order_sync_q <= {order_sync_q[0], burst_order_strap};
    end
  end
  assign linear = (order_sync_q[1] == `PSSC_ORDER_LINEAR);

  // Shared terms of the next-cycle decode.
  assign ce_all = !chip_enable_primary_n && chip_enable_secondary && !chip_enable_tertiary_n;
  assign wq     = write_qual(global_write_n, byte_write_enable_n, byte_lane_select_n);

  // Current and next burst addresses from the wraparound counter.
  assign cur_addr  = {base_q, burst_low(start_q, step_q, linear)};
  assign next_addr = {base_q, burst_low(start_q, pssc_burst_t'(step_q + 2'h1), linear)};

  // Next-cycle decode. After sleep, the processor strobe is tested first and only when the primary
  // enable is active, so it wins over the controller strobe and over the write inputs.
  always_comb begin
    state_d  = state_q;
    load_ext = 1'b0;
    step_en  = 1'b0;
    wr_en    = 1'b0;
    rd_use   = 1'b0;
    if (asleep) begin
      state_d = PSSC_ST_SLEEP;
    end else if (!processor_address_strobe_n && !chip_enable_primary_n) begin
      if (ce_all) begin
        state_d  = PSSC_ST_READ;
        load_ext = 1'b1;
        rd_use   = 1'b1;
      end else begin
        state_d = PSSC_ST_IDLE;
      end
    end else if (!controller_address_strobe_n) begin
      if (!ce_all) begin
        state_d = PSSC_ST_IDLE;
      end else if (wq) begin
        state_d  = PSSC_ST_WRITE;
        load_ext = 1'b1;
        wr_en    = 1'b1;
      end else begin
        state_d  = PSSC_ST_READ;
        load_ext = 1'b1;
        rd_use   = 1'b1;
      end
    end else begin
      case (state_q)
        PSSC_ST_READ, PSSC_ST_WRITE: begin
          step_en = !burst_advance_n;
          if (wq) begin
            state_d = PSSC_ST_WRITE;
            wr_en   = 1'b1;
          end else begin
            state_d = PSSC_ST_READ;
            rd_use  = 1'b1;
          end
        end
        default: begin
          state_d = PSSC_ST_IDLE;
        end
      endcase
    end
  end

  // Address used by this cycle: external, next burst beat or current beat.
  always_comb begin
    if (load_ext) begin
      acc_addr = address;
    end else if (step_en) begin
      acc_addr = next_addr;
    end else begin
      acc_addr = cur_addr;
    end
  end

  // Cycle state register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= PSSC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Burst counter: the base holds the upper bits, the counter steps the beat index.
  always_ff @(posedge mclk) begin
    if (rst) begin
      base_q  <= '0;
      start_q <= '0;
      step_q  <= '0;
    end else if (load_ext) begin
      base_q  <= address[ADDR_W-1:2];
      start_q <= address[1:0];
      step_q  <= '0;
    end else if (step_en) begin
      step_q  <= pssc_burst_t'(step_q + 2'h1);
    end
  end

  // Read pipeline: the address used at one edge is fetched into the output
  // register at the next; a read cut off by sleep is simply dropped.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_pend_q <= rd_use;
      rd_addr_q <= acc_addr;
    end
  end

  // Output register loads only when a read is pending; a suspended read loads
  // the current beat again, so it presents the same word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_out_q <= '0;
    end else if (rd_pend_q) begin
      data_out_q <= mem[rd_addr_q];
    end
  end

  // The bus may drive only after the first cycle of a read and only while reading;
  // a deselect, a write or sleep drops it at once. A new begin-read keeps the bus
  // floating for its first cycle, even straight after another read.
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= rd_pend_q && (state_d == PSSC_ST_READ) && !load_ext;
    end
  end

  // One write port per byte lane. Global write overrides the lane selects.
  // Storage has no reset, and nothing writes it while asleep.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_we[i] = wr_en && !asleep && (!global_write_n || !byte_lane_select_n[i]);
  end

  // A single process owns the array, so no word has two writers.
  always_ff @(posedge mclk) begin
    for (int j = 0; j < LANES; j++) begin
      if (lane_we[j]) begin
        mem[acc_addr][j*LANE_W +: LANE_W] <= data_in[j*LANE_W +: LANE_W];
      end
    end
  end

  // Output enable is not sampled: it gates the registered drive directly. This
  // leaves one gate between flop and pin, which is the price of an unclocked enable.
  assign data_oe      = {DATA_W{drive_q && !output_enable_n}};
  assign data_out     = data_out_q;
  assign sleep_active = asleep;
  assign cycle_state  = state_q;

endmodule

/* File: tb/pssc_ctrl_model.sv */
// Bus controller model that drives every synchronous pin of the SRAM.
// Assumes the bench calls its tasks; pins change only at rising mclk.
`timescale 1ns/1ps
module pssc_ctrl_model (
  input  wire logic        mclk,          // Clock.
  input  wire logic [31:0] data_out,      // Design output value.
  input  wire logic [31:0] data_oe,       // Design output enables.
  output logic             sleep_request, // Sleep request.
  output logic             strap,         // Burst order strap.
  output logic [12:0]      ctl,           // Packed control pins.
  output logic [14:0]      addr,          // Word address.
  output logic [31:0]      data_in        // Resolved data pins.
);
  logic [31:0] wd;
  logic        drv;
  // A released bus shows the inverse of the last value, so a stale read cannot pass.
  assign data_in = (data_oe & data_out) | (~data_oe & (drv ? wd : ~wd));
  initial begin
    sleep_request = 1'b0;
    strap = 1'b0;
    ctl = 13'h1FFB;
    addr = '0;
    wd = '0;
    drv = 1'b0;
  end
  // One bus cycle, held until the next edge.
  task automatic cyc(input logic [12:0] v, input logic [14:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    ctl <= v;
    addr <= a;
    wd <= d;
    drv <= w;
    #1;
  endtask
  task automatic set_strap(input logic v);
    @(posedge mclk);
    strap <= v;
    #1;
  endtask
  // Deselect before the request moves, then keep enables and strobes quiet.
  task automatic nap(input logic on);
    cyc(13'h1FEB, '0, '0, 1'b0);
    @(posedge mclk);
    sleep_request <= on;
    #1;
    repeat (3) cyc(13'h1FFB, '0, '0, 1'b0);
  endtask
endmodule

/* File: tb/pssc_sva.sv */
// Port assertions for the SRAM cycle-control block.
// Assumes one clock domain; bound to every pssc_top by the line at the foot.
`timescale 1ns/1ps
module pssc_sva
  import pssc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int LANES  = 4
) (
  input wire logic              mclk,                        // Clock.
  input wire logic              rst,                         // Reset.
  input wire logic              sleep_request,               // Sleep request.
  input wire logic              chip_enable_primary_n,       // Enable one.
  input wire logic              chip_enable_secondary,       // Enable two.
  input wire logic              chip_enable_tertiary_n,      // Enable three.
  input wire logic              processor_address_strobe_n,  // Strobe P.
  input wire logic              controller_address_strobe_n, // Strobe C.
  input wire logic              global_write_n,              // Global write.
  input wire logic              byte_write_enable_n,         // Byte write.
  input wire logic [LANES-1:0]  byte_lane_select_n,          // Lanes.
  input wire logic              output_enable_n,             // Output enable.
  input wire logic [DATA_W-1:0] data_oe,                     // Drive enables.
  input wire logic              sleep_active,                // Asleep.
  input wire pssc_pkg::pssc_cycle_t cycle_state              // Cycle kind.
);
  logic awake, en, wq, ps, cs;
  // Decoded controls; a sleep pulse shorter than a cycle is never sent.
  assign awake = !sleep_request && !sleep_active;
  assign en = !chip_enable_primary_n && chip_enable_secondary && !chip_enable_tertiary_n;
  assign wq = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
  assign ps = !processor_address_strobe_n;
  assign cs = !controller_address_strobe_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_cont;
    awake && !ps && !cs && !wq && cycle_state == PSSC_ST_READ;
  endsequence
  sequence s_nap_on;
    $rose(sleep_request) ##1 sleep_request;
  endsequence
  sequence s_nap_off;
    $fell(sleep_request) ##1 !sleep_request;
  endsequence
  a_sleep_entry: assert property (s_nap_on |-> !sleep_active ##1 sleep_active)
    else $error("sleep entry timing wrong");
  a_sleep_exit: assert property (s_nap_off |-> sleep_active ##1 !sleep_active ##1 cycle_state == PSSC_ST_IDLE)
    else $error("sleep exit timing wrong");
  a_sleep_floats: assert property (sleep_active |-> data_oe == '0)
    else $error("bus driven while asleep");
  a_write_masked: assert property (cycle_state == PSSC_ST_WRITE |-> data_oe == '0)
    else $error("bus driven in write cycle");
  a_oe_gates_bus: assert property (output_enable_n |-> data_oe == '0)
    else $error("bus driven with output enable high");
  a_deselect_idle: assert property (awake && ((cs && chip_enable_primary_n) || (!chip_enable_primary_n && (ps || cs) && !en))
    |=> cycle_state == PSSC_ST_IDLE && data_oe == '0)
    else $error("deselect not taken");
  a_begin_read: assert property (awake && ps && en |=> cycle_state == PSSC_ST_READ && data_oe == '0)
    else $error("processor strobe read not begun");
  a_ctl_write: assert property (awake && !ps && cs && en && wq |=> cycle_state == PSSC_ST_WRITE)
    else $error("controller strobe write not taken");
  a_ctl_read: assert property (awake && !ps && cs && en && !wq |=> cycle_state == PSSC_ST_READ)
    else $error("controller strobe read not begun");
  a_cont_drive: assert property (s_cont |=> cycle_state == PSSC_ST_READ && data_oe == {DATA_W{!output_enable_n}})
    else $error("continued read drive wrong");
endmodule
bind pssc_top pssc_sva #(.DATA_W(DATA_W), .LANES(LANES)) pssc_sva_i (.*);

/* File: tb/tb_pipelined_sync_sram_cycle_control.sv */
// Self-checking bench for the SRAM cycle-control block.
// Assumes the controller model owns every bus pin of the design.
`timescale 1ns/1ps
module tb_pipelined_sync_sram_cycle_control;
  import pssc_pkg::*;
  localparam logic [12:0] DSEL = 13'h1FEB;
  localparam logic [12:0] RDB  = 13'h1FF2;
  localparam logic [12:0] CONT = 13'h1F9A;
  localparam logic [4:0]  ROWS [5] = '{5'h03, 5'h16, 5'h10, 5'h0E, 5'h08};
  logic        mclk, rst, sleep_request, strap, sleep_active;
  logic [12:0] ctl;
  logic [14:0] addr;
  logic [31:0] data_in, data_out, data_oe;
  pssc_cycle_t cycle_state;
  int          n_errors, checked, ticks;
  pssc_top pssc_top_i (.mclk(mclk), .rst(rst), .sleep_request(sleep_request), .burst_order_strap(strap),
    .chip_enable_primary_n(ctl[0]), .chip_enable_secondary(ctl[1]), .chip_enable_tertiary_n(ctl[2]),
    .processor_address_strobe_n(ctl[3]), .controller_address_strobe_n(ctl[4]), .burst_advance_n(ctl[5]),
    .output_enable_n(ctl[6]), .byte_lane_select_n(ctl[10:7]), .byte_write_enable_n(ctl[11]),
    .global_write_n(ctl[12]), .address(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .sleep_active(sleep_active), .cycle_state(cycle_state));
  pssc_ctrl_model pssc_ctrl_model_i (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
    .sleep_request(sleep_request), .strap(strap), .ctl(ctl), .addr(addr), .data_in(data_in));
  // Free-running clock and a cycle ceiling well above the expected run.
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 2000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] pat(input logic [14:0] i);
    return {17'h1A5C3, i};
  endfunction
  // Controller-strobe write with output enable already high.
  task automatic wr(input logic [14:0] a, input logic [31:0] d, input logic [5:0] w);
    pssc_ctrl_model_i.cyc({w, 7'h6A}, a, d, 1'b1);
  endtask
  task automatic rd1(input logic [14:0] a, input logic [31:0] e);
    pssc_ctrl_model_i.cyc(RDB, a, '0, 1'b0);
    pssc_ctrl_model_i.cyc(13'h1FBA, a, '0, 1'b0);
    pssc_ctrl_model_i.cyc(DSEL, a, '0, 1'b0);
    chk(data_out, e);
  endtask
  task automatic t_burst(input logic m);
    logic [1:0] x;
    pssc_ctrl_model_i.set_strap(m);
    for (int i = 0; i < 4; i++) wr(15'h0100 + 15'(i), pat(15'h0100 + 15'(i)), 6'h1F);
    for (int st = 0; st < 4; st++) begin
      pssc_ctrl_model_i.cyc(RDB, 15'h0100 + 15'(st), '0, 1'b0);
      for (int k = 0; k < 5; k++) begin
        pssc_ctrl_model_i.cyc(k < 4 ? CONT : DSEL, '0, '0, 1'b0);
        x = m ? 2'(st) ^ 2'(k - 1) : 2'(st + k - 1);
        if (k > 0) chk(data_out, pat(15'h0100 + 15'(x)));
        if (k > 0 && k < 4) chk(data_oe, '1);
      end
    end
    $display("burst test done, order %0d", m);
  endtask
  task automatic t_desel();
    foreach (ROWS[i]) begin
      pssc_ctrl_model_i.cyc(RDB, 15'h0100, '0, 1'b0);
      pssc_ctrl_model_i.cyc(CONT, '0, '0, 1'b0);
      pssc_ctrl_model_i.cyc({8'hFD, ROWS[i]}, '0, '0, 1'b0);
      pssc_ctrl_model_i.cyc(13'h1FBA, '0, '0, 1'b0);
      chk({28'h0, cycle_state}, {28'h0, PSSC_ST_IDLE});
      chk(data_oe, '0);
    end
    $display("deselect test done");
  endtask
  task automatic t_bytes();
    wr(15'h0200, 32'h11223344, 6'h1F);
    pssc_ctrl_model_i.cyc({6'h00, 7'h72}, 15'h0200, 32'hFFFFFFFF, 1'b1);
    pssc_ctrl_model_i.cyc({6'h2A, 7'h7A}, 15'h0000, 32'hAABBCCDD, 1'b1);
    chk({28'h0, cycle_state}, {28'h0, PSSC_ST_READ});
    pssc_ctrl_model_i.cyc({6'h2A, 7'h3A}, 15'h0000, 32'hAABBCCDD, 1'b1);
    chk({28'h0, cycle_state}, {28'h0, PSSC_ST_WRITE});
    chk(data_oe, '0);
    wr(15'h0200, 32'h0, 6'h2F);
    rd1(15'h0200, 32'h11BB33DD);
    $display("byte write test done");
  endtask
  task automatic t_sleep();
    wr(15'h0300, 32'h5EED0001, 6'h1F);
    pssc_ctrl_model_i.nap(1'b1);
    repeat (2) wr(15'h0300, 32'h0BAD0BAD, 6'h1F);
    chk({31'h0, sleep_active}, 32'h1);
    chk({28'h0, cycle_state}, {28'h0, PSSC_ST_SLEEP});
    chk(data_oe, '0);
    pssc_ctrl_model_i.nap(1'b0);
    chk({31'h0, sleep_active}, 32'h0);
    rd1(15'h0300, 32'h5EED0001);
    $display("sleep test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    n_errors = 0;
    checked = 0;
    ticks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_burst(1'b0);
    t_burst(1'b1);
    t_desel();
    t_bytes();
    t_sleep();
    report_and_stop();
  end
endmodule
